// ---- src/bus_ctl_pkg.sv ----
// Constants and carriers for the serial bus control/status register block.
// Assumes one system clock; bus events arrive as one-cycle pulses.
package bus_ctl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTL_ADDR = 8'hC0;
  localparam logic [7:0] CTL_PAGE = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ROLE_BIT = 7;
  localparam int TXDIR_BIT = 6;
  localparam int OPEN_BIT = 5;
  localparam int CLOSE_BIT = 4;
  localparam int ACKNOWLEDGE_REQUEST_BIT = 3;
  localparam int ARB_BIT = 2;
  localparam int ACK_BIT = 1;
  localparam int EVT_BIT = 0;

  // ****************************************
  // Carriers
  // ****************************************
  // Register access from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
  } sfr_req_s;

  // Bus engine event pulses
  typedef struct packed {
    logic start_gen;
    logic stop_gen;
    logic start_det;
    logic rstart_det;
    logic stop_det;
    logic addr_rcvd;
    logic slave_addressed;
    logic byte_sent;
    logic byte_rcvd;
    logic ack_cycle_done;
    logic ack_in;
    logic scl_low_at_cond;
    logic sda_low_on_one;
    logic data_written;
    logic frame_start;
  } bus_evt_s;

  // Commands to the bus engine
  typedef struct packed {
    logic gen_start;
    logic gen_stop;
    logic release_ev;
    logic hold_scl;
    logic ack_out;
  } bus_cmd_s;

endpackage : bus_ctl_pkg

// ---- src/bus_ctl_status.sv ----
// Control and status register of the serial bus interface.
// Assumes a bus engine that pulses events and obeys the command outputs.
`timescale 1ns/1ns
`default_nettype none

module bus_ctl_status (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register access
  input wire bus_ctl_pkg::sfr_req_s req_in,
  output logic [7:0] rdata_out,
  // Configuration
  input wire logic auto_ack_enable_in,
  // Bus engine events
  input wire logic evt_valid_in,
  input wire bus_ctl_pkg::bus_evt_s evt_in,
  output logic evt_ready_out,
  // Commands to bus engine
  output bus_ctl_pkg::bus_cmd_s cmd_out
);

  // ****************************************
  // Event buffer
  // ****************************************
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic stop_pending_q;
  bus_ctl_pkg::bus_evt_s buf_q [2];
  logic [1:0] cnt_q;
  logic rd_ptr_q;
  logic wr_ptr_q;
  wire logic buf_push = evt_valid_in && evt_ready_out;
  wire logic buf_valid = (cnt_q != 2'h0);
  wire logic stall = ctl_q[bus_ctl_pkg::EVT_BIT];
  wire logic buf_pop = buf_valid && !stall;
  wire bus_ctl_pkg::bus_evt_s ev = buf_q[rd_ptr_q];
  wire logic ev_ok = buf_pop && ce_in;

  assign evt_ready_out = (cnt_q != 2'h2);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 2'h0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else if (ce_in) begin
      if (buf_push) begin
        buf_q[wr_ptr_q] <= evt_in;
        wr_ptr_q <= !wr_ptr_q;
      end
      if (buf_pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  wire logic sel = (req_in.addr == bus_ctl_pkg::CTL_ADDR) &&
    (req_in.page == bus_ctl_pkg::CTL_PAGE);
  wire logic byte_wr = sel && req_in.wr && !req_in.bit_wr;
  wire logic bit_wr = sel && req_in.bit_wr;
  // Merged image of software write, one bit or whole byte
  logic [7:0] wr_img;
  logic [7:0] wr_mask;
  always_comb begin
    wr_img = req_in.wdata;
    wr_mask = 8'h00;
    if (byte_wr) begin
      wr_mask = 8'hFF;
    end else if (bit_wr) begin
      wr_mask = 8'h01 << req_in.bit_sel;
      wr_img = {8{req_in.bit_val}};
    end
  end
  wire logic w_open = wr_mask[bus_ctl_pkg::OPEN_BIT];
  wire logic w_close = wr_mask[bus_ctl_pkg::CLOSE_BIT];
  wire logic w_ack = wr_mask[bus_ctl_pkg::ACK_BIT];
  wire logic w_evt = wr_mask[bus_ctl_pkg::EVT_BIT];
  wire logic evt_clear = w_evt && !wr_img[bus_ctl_pkg::EVT_BIT];

  // ****************************************
  // Event decode
  // ****************************************
  wire logic is_master = ctl_q[bus_ctl_pkg::ROLE_BIT];
  wire logic unwanted_rs = ev_ok && ev.rstart_det && is_master &&
    !ctl_q[bus_ctl_pkg::OPEN_BIT];
  wire logic arb_loss = unwanted_rs || (ev_ok && (ev.scl_low_at_cond ||
    ev.sda_low_on_one));
  wire logic stop_loss = arb_loss && ev.stop_det;
  wire logic hw_event = ev_ok && (ev.start_gen || ev.byte_sent ||
    ev.byte_rcvd || ev.addr_rcvd || ev.stop_det);

  // ****************************************
  // Next register value
  // ****************************************
  always_comb begin
    ctl_d = ctl_q;
    // Writable bits first, hardware overrides after
    if (w_open) ctl_d[bus_ctl_pkg::OPEN_BIT] = wr_img[bus_ctl_pkg::OPEN_BIT];
    if (w_close) begin
      ctl_d[bus_ctl_pkg::CLOSE_BIT] = wr_img[bus_ctl_pkg::CLOSE_BIT];
    end
    if (w_ack) ctl_d[bus_ctl_pkg::ACK_BIT] = wr_img[bus_ctl_pkg::ACK_BIT];
    if (w_evt) ctl_d[bus_ctl_pkg::EVT_BIT] = wr_img[bus_ctl_pkg::EVT_BIT];
    if (evt_clear) ctl_d[bus_ctl_pkg::ARB_BIT] = 1'b0;
    // Role
    if (ev_ok && ev.start_gen) ctl_d[bus_ctl_pkg::ROLE_BIT] = 1'b1;
    if ((ev_ok && ev.stop_gen) || arb_loss) begin
      ctl_d[bus_ctl_pkg::ROLE_BIT] = 1'b0;
    end
    // Direction
    if (ev_ok && ev.frame_start) begin
      ctl_d[bus_ctl_pkg::TXDIR_BIT] = ev.data_written;
    end
    if (ev_ok && ev.start_det) ctl_d[bus_ctl_pkg::TXDIR_BIT] = 1'b0;
    if (ev_ok && ev.start_gen) ctl_d[bus_ctl_pkg::TXDIR_BIT] = 1'b1;
    if (arb_loss) ctl_d[bus_ctl_pkg::TXDIR_BIT] = 1'b0;
    // Opening flag, set only
    if (ev_ok && ev.addr_rcvd && (ev.start_det || ev.rstart_det)) begin
      ctl_d[bus_ctl_pkg::OPEN_BIT] = 1'b1;
    end
    // Closing flag
    if (ev_ok && ev.stop_gen && stop_pending_q) begin
      ctl_d[bus_ctl_pkg::CLOSE_BIT] = 1'b0;
    end
    if ((ev_ok && ev.stop_det && ev.slave_addressed) || stop_loss) begin
      ctl_d[bus_ctl_pkg::CLOSE_BIT] = 1'b1;
    end
    // Ack request
    if (ev_ok && ev.ack_cycle_done) ctl_d[bus_ctl_pkg::ACKNOWLEDGE_REQUEST_BIT] = 1'b0;
    if (ev_ok && ev.byte_rcvd && !auto_ack_enable_in) begin
      ctl_d[bus_ctl_pkg::ACKNOWLEDGE_REQUEST_BIT] = 1'b1;
    end
    // Arbitration lost, set wins over clear
    if (arb_loss) ctl_d[bus_ctl_pkg::ARB_BIT] = 1'b1;
    // Incoming ack while transmitting
    if (ev_ok && ev.byte_sent) begin
      ctl_d[bus_ctl_pkg::ACK_BIT] = !ev.ack_in;
    end
    // Event flag, set wins over clear
    if (hw_event || arb_loss) ctl_d[bus_ctl_pkg::EVT_BIT] = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctl_q <= bus_ctl_pkg::CTL_RESET;
    end else if (ce_in) begin
      ctl_q <= ctl_d;
    end
  end

  // ****************************************
  // Command generation
  // ****************************************
  logic start_req_q;
  logic rel_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stop_pending_q <= 1'b0;
      start_req_q <= 1'b0;
      rel_q <= 1'b0;
    end else if (ce_in) begin
      rel_q <= evt_clear && stall;
      if (w_close && wr_img[bus_ctl_pkg::CLOSE_BIT] && is_master) begin
        stop_pending_q <= 1'b1;
      end else if (ev_ok && ev.stop_gen) begin
        stop_pending_q <= 1'b0;
      end
      if (w_open && wr_img[bus_ctl_pkg::OPEN_BIT]) begin
        start_req_q <= 1'b1;
      end else if (ev_ok && ev.start_gen) begin
        start_req_q <= 1'b0;
      end
    end
  end

  assign cmd_out.gen_stop = stop_pending_q;
  assign cmd_out.gen_start = start_req_q && !stop_pending_q;
  assign cmd_out.release_ev = rel_q;
  assign cmd_out.hold_scl = stall;
  // Outgoing ack: hardware uses ack bit whether auto or firmware supplied
  assign cmd_out.ack_out = ctl_q[bus_ctl_pkg::ACK_BIT];
  assign rdata_out = ctl_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_role_set;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && ev_ok && ev.start_gen && !arb_loss && !ev.stop_gen)
      |=> ctl_q[bus_ctl_pkg::ROLE_BIT];
  endproperty
  a_role_set: assert property (p_role_set)
    else $error("role flag not set on start");

  property p_txdir_loss;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && arb_loss) |=> !ctl_q[bus_ctl_pkg::TXDIR_BIT];
  endproperty
  a_txdir_loss: assert property (p_txdir_loss)
    else $error("direction not cleared on loss");

  property p_open_hold;
    @(posedge clk_in) disable iff (rst_in)
    (ctl_q[bus_ctl_pkg::OPEN_BIT] && !(ce_in && w_open))
      |=> ctl_q[bus_ctl_pkg::OPEN_BIT];
  endproperty
  a_open_hold: assert property (p_open_hold)
    else $error("opening flag cleared by hardware");

  property p_arb_clear;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && evt_clear && !arb_loss) |=> !ctl_q[bus_ctl_pkg::ARB_BIT];
  endproperty
  a_arb_clear: assert property (p_arb_clear)
    else $error("arbitration lost not cleared");

  property p_evt_set;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && (hw_event || arb_loss)) |=> ctl_q[bus_ctl_pkg::EVT_BIT];
  endproperty
  a_evt_set: assert property (p_evt_set)
    else $error("event flag not set");

  property p_stall;
    @(posedge clk_in) disable iff (rst_in)
    ctl_q[bus_ctl_pkg::EVT_BIT] |-> (cmd_out.hold_scl && !buf_pop);
  endproperty
  a_stall: assert property (p_stall)
    else $error("bus not stalled");

  property p_acknowledge_request;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && ev_ok && ev.byte_rcvd && !auto_ack_enable_in)
      |=> ctl_q[bus_ctl_pkg::ACKNOWLEDGE_REQUEST_BIT];
  endproperty
  a_acknowledge_request: assert property (p_acknowledge_request)
    else $error("ack request not set");

  property p_stop_first;
    @(posedge clk_in) disable iff (rst_in)
    stop_pending_q |-> !cmd_out.gen_start;
  endproperty
  a_stop_first: assert property (p_stop_first)
    else $error("start before pending stop");

  c_start: cover property (@(posedge clk_in) ev_ok && ev.start_gen);
  c_loss: cover property (@(posedge clk_in) arb_loss);
  c_full: cover property (@(posedge clk_in) !evt_ready_out);

endmodule // bus_ctl_status

`default_nettype wire

// ---- verif/bus_ctl_status_tb_top.sv ----
// Self-checking bench for the control and status register block.
// Assumes the bus engine model drives the event port.
`timescale 1ns/1ns
`default_nettype none

module bus_ctl_status_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ack_en = 1'b0;
  logic ev_valid;
  logic ev_ready;
  logic [7:0] rdata;
  bus_ctl_pkg::sfr_req_s req = '0;
  bus_ctl_pkg::bus_evt_s ev_w;
  bus_ctl_pkg::bus_evt_s e;
  bus_ctl_pkg::bus_cmd_s cmd;
  int err_count = 0;
  int comparisons = 0;
  int rel_seen = 0;

  always #10 clk_in = ~clk_in;

  // Counts release pulses, one per cleared pending event
  always @(posedge clk_in) begin
    if (cmd.release_ev === 1'b1) rel_seen++;
  end

  bus_ctl_status DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .req_in(req), .rdata_out(rdata), .auto_ack_enable_in(ack_en),
    .evt_valid_in(ev_valid), .evt_in(ev_w), .evt_ready_out(ev_ready),
    .cmd_out(cmd));

  bus_engine_model M (.clk_in(clk_in), .ready_in(ev_ready),
    .valid_out(ev_valid), .evt_out(ev_w));

  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, s, x);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req = '0;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_in);
    req = '0;
    @(negedge clk_in);
  endtask

  task automatic bw(input logic [2:0] sel, input logic v);
    @(negedge clk_in);
    req = '0;
    req.bit_wr = 1'b1;
    req.addr = bus_ctl_pkg::CTL_ADDR;
    req.bit_sel = sel;
    req.bit_val = v;
    @(negedge clk_in);
    req = '0;
    repeat (3) @(negedge clk_in);
  endtask

  task automatic snd(input bus_ctl_pkg::bus_evt_s x);
    M.send(x);
    repeat (3) @(negedge clk_in);
  endtask

  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(rdata, bus_ctl_pkg::CTL_RESET);
    wr(8'hC1, 8'hFF);
    chk(rdata, 8'h00);
    wr(8'hC0, 8'hFF);
    chk(rdata, 8'h33);
    wr(8'hC0, 8'h00);
    e = '0; e.rstart_det = 1'b1; e.addr_rcvd = 1'b1; snd(e);
    chk(rdata, 8'h21);
    wr(8'hC0, 8'h00);
    chk(rdata, 8'h00);
    e = '0; e.stop_det = 1'b1; e.slave_addressed = 1'b1; snd(e);
    chk(rdata, 8'h11);
    wr(8'hC0, 8'h20);
    chk(8'(cmd.gen_start), 8'h01);
    e = '0; e.start_gen = 1'b1; snd(e);
    chk(rdata, 8'hE1);
    chk(8'(cmd.hold_scl), 8'h01);
    chk(8'(cmd.gen_start), 8'h00);
    bw(3'h0, 1'b0);
    chk(rdata, 8'hE0);
    chk(8'(cmd.hold_scl), 8'h00);
    bw(3'h4, 1'b1);
    chk(rdata, 8'hF0);
    chk(8'(cmd.gen_stop), 8'h01);
    e = '0; e.ack_cycle_done = 1'b1; e.stop_gen = 1'b1; snd(e);
    chk(rdata, 8'h60);
    chk(8'(cmd.gen_stop), 8'h00);
    e = '0; e.start_gen = 1'b1; snd(e);
    bw(3'h0, 1'b0);
    e = '0; e.sda_low_on_one = 1'b1; snd(e);
    chk(rdata, 8'h25);
    bw(3'h0, 1'b0);
    chk(rdata, 8'h20);
    wr(8'hC0, 8'h00);
    e = '0; e.byte_rcvd = 1'b1; snd(e);
    chk(rdata, 8'h09);
    bw(3'h1, 1'b1);
    chk(8'(cmd.ack_out), 8'h01);
    bw(3'h0, 1'b0);
    e = '0; e.byte_sent = 1'b1; e.ack_cycle_done = 1'b1; e.ack_in = 1'b1;
    snd(e);
    chk(rdata, 8'h01);
    e = '0; e.byte_rcvd = 1'b1; snd(e);
    snd(e);
    chk(8'(ev_ready), 8'h00);
    chk(rdata, 8'h01);
    bw(3'h0, 1'b0);
    chk(rdata, 8'h09);
    chk(8'(ev_ready), 8'h01);
    chk(8'(rel_seen), 8'h08);
    end_sim();
  end
endmodule // bus_ctl_status_tb_top

`default_nettype wire

// ---- verif/bus_engine_model.sv ----
// Model of the bus engine that feeds event words to the register block.
// Assumes the block samples valid and ready on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module bus_engine_model (
  // Clock
  input wire logic clk_in,
  // Handshake
  input wire logic ready_in,
  output logic valid_out,
  output bus_ctl_pkg::bus_evt_s evt_out
);
  initial begin
    valid_out = 1'b0;
    evt_out = '0;
  end

  // Holds the word until ready is seen, then shows a changed pattern
  task automatic send(input bus_ctl_pkg::bus_evt_s e);
    @(negedge clk_in);
    valid_out = 1'b1;
    evt_out = e;
    while (ready_in !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    @(negedge clk_in);
    valid_out = 1'b0;
    evt_out = ~e;
  endtask
endmodule // bus_engine_model

`default_nettype wire
